/* File: hdl/ams_map.svh */
// Purpose: register map, field positions, reset values and timing counts of the measurement sequencer
// Assumes: 40 MHz system clock, AXI4-Lite byte addresses, one 32-bit word per register
// Notes: the result registers sit at consecutive words, indexed by channel code
//
// Functional notes
// - a port-scan command converts both battery and both auxiliary inputs, four results
// - after a port scan all four results are written, then result_ready_n goes low
// - battery and auxiliary results occupy consecutive addresses for one burst read
// - port scan lasts 7.5 us + reference delay + 4 x averages x (bits/fconv + 4.4 us)
// - single measurement lasts 2.625 us + reference delay + averages x (bits/fconv + 4.4 us)
// - battery divider is switched on only while a battery input is sampled
// - first battery input reaches the converter through a divide-by-four network
// - single temperature mode converts the diode once at the low 20 uA bias
// - differential mode adds a second diode conversion at 82x bias, stored separately
// - auxiliary inputs use the battery sequence but connect directly, no divider
// - on-demand reference powers up only during a measurement, from its start, ahead of the reference delay
// - a DAC control bit powers the DAC; cleared means powered down
// - host writes an 8-bit DAC code which sets the output current
// - with averaging, several conversions per channel, only the average stored
`ifndef AMS_MAP_SVH
`define AMS_MAP_SVH

`define AMS_REG_CTRL 6'h00
`define AMS_REG_STATUS 6'h01
`define AMS_REG_IRQ_STS 6'h02
`define AMS_REG_IRQ_MASK 6'h03
`define AMS_REG_DAC_CTRL 6'h04
`define AMS_REG_DAC_DATA 6'h05
`define AMS_REG_RES_BASE 6'h08

`define AMS_CTRL_CMD 2:0
`define AMS_CTRL_AVG 4:3
`define AMS_CTRL_RES 6:5
`define AMS_CTRL_REF_DEMAND 7
`define AMS_CTRL_RST 8'hC0

`define AMS_IRQ_DONE 0
`define AMS_IRQ_SCAN 1
`define AMS_IRQ_OVERRUN 2

`define AMS_CLK_MHZ 40
`define AMS_CYC(ns) ((((ns) * `AMS_CLK_MHZ) + 999) / 1000)
`define AMS_T_SINGLE_NS 2625
`define AMS_T_SCAN_NS 7500
`define AMS_T_ACQ_NS 4400
`define AMS_SINGLE_CYC `AMS_CYC(`AMS_T_SINGLE_NS)
`define AMS_SCAN_CYC `AMS_CYC(`AMS_T_SCAN_NS)
`define AMS_ACQ_CYC `AMS_CYC(`AMS_T_ACQ_NS)

`endif

/* File: hdl/ams_pkg.sv */
// Purpose: types shared by the measurement sequencer
// Assumes: nothing beyond the register map header
// Notes: channel codes double as result word indexes
package ams_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SETUP = 3'h1,
      ST_REF = 3'h3,
      ST_ACQ = 3'h2,
      ST_CONV = 3'h6
   } ams_state_t;

   typedef enum logic [2:0] {
      CMD_NONE = 3'h0,
      CMD_TEMP_SINGLE = 3'h1,
      CMD_TEMP_DIFF = 3'h2,
      CMD_BAT_A = 3'h3,
      CMD_BAT_B = 3'h4,
      CMD_AUX_A = 3'h5,
      CMD_AUX_B = 3'h6,
      CMD_SCAN = 3'h7
   } ams_cmd_t;

   typedef enum logic [2:0] {
      CH_BAT_A = 3'h0,
      CH_BAT_B = 3'h1,
      CH_AUX_A = 3'h2,
      CH_AUX_B = 3'h3,
      CH_TEMP_LO = 3'h4,
      CH_TEMP_HI = 3'h5
   } ams_chan_t;

   // analog front-end controls
   typedef struct packed {
      ams_chan_t mux_sel;
      logic bat_div_en;
      logic div_quarter;
      logic bias_high;
      logic sample;
      logic convert;
      logic ref_on;
   } ams_afe_t;

endpackage

/* File: hdl/ams_tick_div.sv */
// Purpose: conversion clock enable divider
// Assumes: single system clock
// Notes: clearing restarts the period so the first tick is a full period later
`timescale 1ns/1ps
`default_nettype none
module ams_tick_div #(
   parameter int DIV = 10
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // control
   input wire logic clr_i,
   output logic tick_o
);
   logic [15:0] cnt_q;

   assign tick_o = (cnt_q == 16'(DIV - 1));

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= 16'h0000;
      end else if (clr_i || tick_o) begin
         cnt_q <= 16'h0000;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end
endmodule
`default_nettype wire

/* File: hdl/ams_avg_acc.sv */
// Purpose: averaging accumulator for conversion samples
// Assumes: sample counts are powers of two
// Notes: avg_o already includes the sample on sample_i, so the final store needs no extra cycle
`timescale 1ns/1ps
`default_nettype none
module ams_avg_acc #(
   parameter int DW = 12,
   parameter int SW = 4
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // accumulate
   input wire logic clr_i,
   input wire logic add_i,
   input wire logic [DW-1:0] sample_i,
   input wire logic [2:0] shift_i,
   output logic [DW-1:0] avg_o
);
   logic [DW+SW-1:0] acc_q;
   logic [DW+SW-1:0] sum;

   assign sum = acc_q + {{SW{1'b0}}, sample_i};
   assign avg_o = DW'(sum >> shift_i);

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         acc_q <= '0;
      end else if (clr_i) begin
         acc_q <= '0;
      end else if (add_i) begin
         acc_q <= sum;
      end
   end
endmodule
`default_nettype wire

/* File: hdl/ams_measure_seq.sv */
// Purpose: temperature, battery, auxiliary and port-scan sequencer with contrast DAC control
// Assumes: AXI4-Lite slave, ADC result valid on adc_result_i at the last conversion tick
// Notes: analog switching is expressed as afe_o controls; the DAC code drives current_sink_out
`include "ams_map.svh"
`timescale 1ns/1ps
`default_nettype none
module ams_measure_seq
   import ams_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int CONV_DIV = 10,
   parameter int REF_DELAY_CYC = 100
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // axi4-lite write
   input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // converter and front end
   input wire logic [11:0] adc_result_i,
   output ams_afe_t afe_o,
   // host signalling
   output logic result_ready_n_o,
   output logic irq_o,
   // contrast dac
   output logic dac_power_o,
   output logic [7:0] current_sink_out_o
);
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // first and last channel of each command
   function automatic ams_chan_t first_chan(input ams_cmd_t c);
      unique case (c)
         CMD_TEMP_SINGLE, CMD_TEMP_DIFF: first_chan = CH_TEMP_LO;
         CMD_BAT_B: first_chan = CH_BAT_B;
         CMD_AUX_A: first_chan = CH_AUX_A;
         CMD_AUX_B: first_chan = CH_AUX_B;
         default: first_chan = CH_BAT_A;
      endcase
   endfunction

   function automatic ams_chan_t last_chan(input ams_cmd_t c);
      unique case (c)
         CMD_TEMP_SINGLE: last_chan = CH_TEMP_LO;
         CMD_TEMP_DIFF: last_chan = CH_TEMP_HI;
         CMD_BAT_B: last_chan = CH_BAT_B;
         CMD_AUX_A: last_chan = CH_AUX_A;
         CMD_AUX_B, CMD_SCAN: last_chan = CH_AUX_B;
         default: last_chan = CH_BAT_A;
      endcase
   endfunction

   // bus state
   logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   // registers
   logic [7:0] ctrl_q;
   logic [2:0] irq_sts_q, irq_mask_q;
   logic dac_ctrl_q;
   logic [7:0] dac_data_q;
   logic [15:0] res_q [0:5];
   logic ready_n_q;
   // sequencer
   ams_state_t state_q;
   ams_cmd_t cmd_q;
   ams_chan_t chan_q;
   logic [15:0] cnt_q;
   logic [3:0] bit_cnt_q, avg_cnt_q;
   ams_afe_t afe_q;

   logic do_write, ar_hs, wr_ctrl, start, overrun, last_sample, finish, rd_result, tick;
   logic [5:0] wr_idx, rd_idx;
   logic [31:0] rd_data;
   logic rd_err, wr_err;
   logic [3:0] nbits, navg;
   logic [2:0] avg_shift;
   logic [11:0] sample, avg;
   logic [2:0] events;
   ams_afe_t afe_d;

   assign s_axi_awready_o = !aw_full_q && !bvalid_q;
   assign s_axi_wready_o = !w_full_q && !bvalid_q;
   assign s_axi_arready_o = !rvalid_q;
   assign s_axi_bvalid_o = bvalid_q;
   assign s_axi_bresp_o = bresp_q;
   assign s_axi_rvalid_o = rvalid_q;
   assign s_axi_rdata_o = rdata_q;
   assign s_axi_rresp_o = rresp_q;

   assign do_write = aw_full_q && w_full_q && !bvalid_q;
   assign ar_hs = s_axi_arvalid_i && s_axi_arready_o;
   assign wr_idx = awaddr_q[7:2];
   assign rd_idx = s_axi_araddr_i[7:2];
   assign wr_err = (awaddr_q[1:0] != 2'h0) || !(wr_idx == `AMS_REG_CTRL || wr_idx == `AMS_REG_IRQ_STS ||
      wr_idx == `AMS_REG_IRQ_MASK || wr_idx == `AMS_REG_DAC_CTRL || wr_idx == `AMS_REG_DAC_DATA);
   assign wr_ctrl = do_write && (wr_idx == `AMS_REG_CTRL) && wstrb_q[0];
   assign start = wr_ctrl && (wdata_q[`AMS_CTRL_CMD] != 3'h0) && (state_q == ST_IDLE);
   assign overrun = wr_ctrl && (wdata_q[`AMS_CTRL_CMD] != 3'h0) && (state_q != ST_IDLE);
   // results are consecutive words so one burst of reads covers a scan
   assign rd_result = ar_hs && (rd_idx >= `AMS_REG_RES_BASE) && (rd_idx < `AMS_REG_RES_BASE + 6'h6);

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_full_q <= 1'b0;
         awaddr_q <= '0;
      end else if (s_axi_awvalid_i && s_axi_awready_o) begin
         aw_full_q <= 1'b1;
         awaddr_q <= s_axi_awaddr_i;
      end else if (do_write) begin
         aw_full_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         w_full_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (s_axi_wvalid_i && s_axi_wready_o) begin
         w_full_q <= 1'b1;
         wdata_q <= s_axi_wdata_i;
         wstrb_q <= s_axi_wstrb_i;
      end else if (do_write) begin
         w_full_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OK;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_err ? RESP_SLVERR : RESP_OK;
      end else if (s_axi_bready_i) begin
         bvalid_q <= 1'b0;
      end
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err = 1'b0;
      if (rd_idx >= `AMS_REG_RES_BASE && rd_idx < `AMS_REG_RES_BASE + 6'h6) begin
         rd_data = {16'h0000, res_q[3'(rd_idx - `AMS_REG_RES_BASE)]};
      end else begin
         unique case (rd_idx)
            `AMS_REG_CTRL: rd_data = {24'h000000, ctrl_q[7:3], cmd_q};
            `AMS_REG_STATUS: rd_data = {24'h000000, chan_q, state_q, ready_n_q, state_q != ST_IDLE};
            `AMS_REG_IRQ_STS: rd_data = {29'h0, irq_sts_q};
            `AMS_REG_IRQ_MASK: rd_data = {29'h0, irq_mask_q};
            `AMS_REG_DAC_CTRL: rd_data = {31'h0, dac_ctrl_q};
            `AMS_REG_DAC_DATA: rd_data = {24'h000000, dac_data_q};
            default: rd_err = 1'b1;
         endcase
      end
      if (s_axi_araddr_i[1:0] != 2'h0) begin
         rd_err = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OK;
      end else if (ar_hs) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_err ? 32'h0000_0000 : rd_data;
         rresp_q <= rd_err ? RESP_SLVERR : RESP_OK;
      end else if (s_axi_rready_i) begin
         rvalid_q <= 1'b0;
      end
   end

   // settings; the command field is not stored, it reads back as the running command
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_q <= `AMS_CTRL_RST;
      end else if (wr_ctrl && state_q == ST_IDLE) begin
         ctrl_q <= {wdata_q[7:3], 3'h0};
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         dac_ctrl_q <= 1'b0;
         dac_data_q <= 8'h00;
      end else if (do_write && wstrb_q[0]) begin
         if (wr_idx == `AMS_REG_DAC_CTRL) begin
            dac_ctrl_q <= wdata_q[0];
         end
         if (wr_idx == `AMS_REG_DAC_DATA) begin
            dac_data_q <= wdata_q[7:0];
         end
      end
   end

   assign dac_power_o = dac_ctrl_q;
   // powered-down dac sinks no current
   assign current_sink_out_o = dac_ctrl_q ? dac_data_q : 8'h00;

   always_comb begin
      unique case (ctrl_q[`AMS_CTRL_RES])
         2'h0: nbits = 4'd8;
         2'h1: nbits = 4'd10;
         default: nbits = 4'd12;
      endcase
      unique case (ctrl_q[`AMS_CTRL_AVG])
         2'h0: avg_shift = 3'd0;
         2'h1: avg_shift = 3'd2;
         2'h2: avg_shift = 3'd3;
         default: avg_shift = 3'd4;
      endcase
      navg = 4'((5'h01 << avg_shift) - 5'h01);
   end

   // right-justify to the selected resolution
   assign sample = adc_result_i >> (4'd12 - nbits);
   assign last_sample = (state_q == ST_CONV) && tick && (bit_cnt_q == nbits - 4'd1) && (avg_cnt_q == navg);
   assign finish = last_sample && (chan_q == last_chan(cmd_q));

   ams_tick_div #(
      .DIV(CONV_DIV)
   ) u_conv_tick (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .clr_i(state_q != ST_CONV),
      .tick_o(tick)
   );

   ams_avg_acc #(
      .DW(12),
      .SW(4)
   ) u_avg (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .clr_i(start || last_sample),
      .add_i((state_q == ST_CONV) && tick && (bit_cnt_q == nbits - 4'd1)),
      .sample_i(sample),
      .shift_i(avg_shift),
      .avg_o(avg)
   );

   // overhead, reference wait, then per sample 4.4 us acquire and nbits conversion ticks
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         cmd_q <= CMD_NONE;
         chan_q <= CH_BAT_A;
         cnt_q <= 16'h0000;
         bit_cnt_q <= 4'h0;
         avg_cnt_q <= 4'h0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (start) begin
                  cmd_q <= ams_cmd_t'(wdata_q[`AMS_CTRL_CMD]);
                  chan_q <= first_chan(ams_cmd_t'(wdata_q[`AMS_CTRL_CMD]));
                  avg_cnt_q <= 4'h0;
                  cnt_q <= (wdata_q[`AMS_CTRL_CMD] == CMD_SCAN) ? 16'(`AMS_SCAN_CYC - 1) : 16'(`AMS_SINGLE_CYC - 1);
                  state_q <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (cnt_q != 16'h0000) begin
                  cnt_q <= cnt_q - 16'h0001;
               end else if (ctrl_q[`AMS_CTRL_REF_DEMAND]) begin
                  cnt_q <= 16'(REF_DELAY_CYC - 1);
                  state_q <= ST_REF;
               end else begin
                  cnt_q <= 16'(`AMS_ACQ_CYC - 1);
                  state_q <= ST_ACQ;
               end
            end
            ST_REF: begin
               if (cnt_q != 16'h0000) begin
                  cnt_q <= cnt_q - 16'h0001;
               end else begin
                  cnt_q <= 16'(`AMS_ACQ_CYC - 1);
                  state_q <= ST_ACQ;
               end
            end
            ST_ACQ: begin
               bit_cnt_q <= 4'h0;
               if (cnt_q != 16'h0000) begin
                  cnt_q <= cnt_q - 16'h0001;
               end else begin
                  state_q <= ST_CONV;
               end
            end
            ST_CONV: begin
               if (tick && bit_cnt_q != nbits - 4'd1) begin
                  bit_cnt_q <= bit_cnt_q + 4'd1;
               end else if (tick) begin
                  cnt_q <= 16'(`AMS_ACQ_CYC - 1);
                  if (avg_cnt_q != navg) begin
                     avg_cnt_q <= avg_cnt_q + 4'd1;
                     state_q <= ST_ACQ;
                  end else if (finish) begin
                     cmd_q <= CMD_NONE;
                     state_q <= ST_IDLE;
                  end else begin
                     // scan walks bat a, bat b, aux a, aux b; diff temp goes low then high bias
                     avg_cnt_q <= 4'h0;
                     chan_q <= ams_chan_t'(chan_q + 3'h1);
                     state_q <= ST_ACQ;
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // each result written only once its average is complete
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < 6; i++) begin
            res_q[i] <= 16'h0000;
         end
      end else if (last_sample) begin
         res_q[chan_q] <= {4'h0, avg};
      end
   end

   // low in the same cycle the last result is stored; finish beats a same-cycle read
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ready_n_q <= 1'b1;
      end else if (finish) begin
         ready_n_q <= 1'b0;
      end else if (rd_result || wr_ctrl) begin
         ready_n_q <= 1'b1;
      end
   end

   assign result_ready_n_o = ready_n_q;

   assign events = {overrun, finish && (cmd_q == CMD_SCAN), finish};

   // set wins over a write-one clear in the same cycle
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_sts_q <= 3'h0;
      end else if (do_write && wr_idx == `AMS_REG_IRQ_STS && wstrb_q[0]) begin
         irq_sts_q <= (irq_sts_q & ~wdata_q[2:0]) | events;
      end else begin
         irq_sts_q <= irq_sts_q | events;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_mask_q <= 3'h0;
      end else if (do_write && wr_idx == `AMS_REG_IRQ_MASK && wstrb_q[0]) begin
         irq_mask_q <= wdata_q[2:0];
      end
   end

   assign irq_o = |(irq_sts_q & irq_mask_q);

   always_comb begin
      afe_d.mux_sel = chan_q;
      // divider draws current, so it is on only while a battery input is sampled
      afe_d.bat_div_en = (state_q == ST_ACQ) && (chan_q == CH_BAT_A || chan_q == CH_BAT_B);
      afe_d.div_quarter = (chan_q == CH_BAT_A);
      // auxiliary channels get neither divider control
      afe_d.bias_high = (chan_q == CH_TEMP_HI);
      afe_d.sample = (state_q == ST_ACQ);
      afe_d.convert = (state_q == ST_CONV);
      afe_d.ref_on = !ctrl_q[`AMS_CTRL_REF_DEMAND] || (state_q != ST_IDLE);
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         afe_q <= '0;
      end else begin
         afe_q <= afe_d;
      end
   end

   assign afe_o = afe_q;
endmodule
`default_nettype wire

/* File: tb/ams_measure_seq_sva.sv */
// Purpose: port-level checks of the measurement sequencer
// Assumes: one clock, asynchronous active-high reset
// Notes: front-end relations are checked on the registered afe_o controls
`timescale 1ns/1ps
`default_nettype none
module ams_measure_seq_sva
   import ams_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // bus
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic s_axi_rready_i,
   input wire logic s_axi_rvalid_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic s_axi_bready_i,
   input wire logic s_axi_bvalid_o,
   // front end and outputs
   input wire ams_afe_t afe_o,
   input wire logic result_ready_n_o,
   input wire logic dac_power_o,
   input wire logic [7:0] current_sink_out_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_acq_end;
      afe_o.sample ##1 !afe_o.sample;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid_i && s_axi_arready_o;
   endsequence
   chk_rd_answer: assert property (s_rd_take |=> s_axi_rvalid_o)
      else $error("read not answered");
   chk_rd_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data dropped");
   chk_wr_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
      else $error("write answer dropped");
   chk_div_bat_only: assert property (afe_o.bat_div_en |-> afe_o.sample && afe_o.mux_sel inside {CH_BAT_A, CH_BAT_B})
      else $error("divider on outside battery acquire");
   chk_quarter_bat_a: assert property (afe_o.sample && afe_o.mux_sel == CH_BAT_A |-> afe_o.div_quarter && afe_o.bat_div_en)
      else $error("battery a not quartered");
   chk_aux_direct: assert property (afe_o.sample && afe_o.mux_sel inside {CH_AUX_A, CH_AUX_B} |-> !afe_o.bat_div_en)
      else $error("aux input divided");
   chk_bias_low: assert property (afe_o.sample && afe_o.mux_sel == CH_TEMP_LO |-> !afe_o.bias_high)
      else $error("low bias reading at high bias");
   chk_bias_high: assert property (afe_o.sample && afe_o.mux_sel == CH_TEMP_HI |-> afe_o.bias_high)
      else $error("high bias reading at low bias");
   chk_ref_up: assert property (afe_o.sample || afe_o.convert |-> afe_o.ref_on)
      else $error("reference off while measuring");
   chk_acq_conv: assert property (s_acq_end |-> afe_o.convert)
      else $error("acquire not followed by conversion");
   chk_dac_off: assert property (!dac_power_o |-> current_sink_out_o == 8'h00)
      else $error("dac drives while powered down");
   chk_ready_rise: assert property ($rose(result_ready_n_o) |-> $rose(s_axi_rvalid_o) || $rose(s_axi_bvalid_o))
      else $error("ready released without host access");
endmodule
`default_nettype wire

/* File: tb/ams_afe_model.sv */
// Purpose: converter and front-end stand-in
// Assumes: result is taken at the last conversion tick
// Notes: even samples of a channel add 4, so averaging shows in the result
`timescale 1ns/1ps
`default_nettype none
module ams_afe_model
   import ams_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // front end
   input wire ams_afe_t afe_i,
   output logic [11:0] adc_result_o,
   // observation
   output logic [11:0] order_o,
   output logic [3:0] count_o
);
   logic prev_q;
   logic [11:0] lvl;
   // divider and bias change what the converter sees
   assign lvl = (12'h400 + {1'b0, afe_i.mux_sel, 8'h00}) >> (afe_i.div_quarter ? 2 : 0);
   assign adc_result_o = lvl + (afe_i.bias_high ? 12'h040 : 12'h000) + (count_o[0] ? 12'h000 : 12'h004);
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         prev_q <= 1'b0;
         order_o <= 12'hFFF;
         count_o <= 4'h0;
      end else begin
         prev_q <= afe_i.sample;
         if (afe_i.sample && !prev_q) begin
            if (afe_i.mux_sel != ams_chan_t'(order_o[2:0])) begin
               order_o <= {order_o[8:0], afe_i.mux_sel};
               count_o <= 4'h1;
            end else begin
               count_o <= count_o + 4'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: tb/test_aux_measure_sequencer.sv */
// Purpose: self-checking bench of the measurement sequencer
// Assumes: conversion divider and reference delay shortened to 2
// Notes: durations get a few cycles of slack for bus latency
`timescale 1ns/1ps
`default_nettype none
module test_aux_measure_sequencer;
   import ams_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
   logic [31:0] wdata = 32'h0, rdata;
   logic awready, wready, bvalid, arready, rvalid, ready_n, irq, dac_pw;
   logic [1:0] bresp, rresp;
   logic [11:0] adc, order;
   logic [3:0] cnt;
   logic [7:0] sink;
   ams_afe_t afe;
   int failures = 0;
   int compares = 0;
   int cycles = 0;
   ams_measure_seq #(.CONV_DIV(2), .REF_DELAY_CYC(2)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .adc_result_i(adc), .afe_o(afe), .result_ready_n_o(ready_n), .irq_o(irq),
      .dac_power_o(dac_pw), .current_sink_out_o(sink));
   ams_afe_model u_afe (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .afe_i(afe), .adc_result_o(adc),
      .order_o(order), .count_o(cnt));
   always #12.5 sys_clk_i = ~sys_clk_i;
   task automatic end_of_test();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 8000) begin
         failures++;
         end_of_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      do @(posedge sys_clk_i); while (bvalid !== 1'b1);
      chk("bresp", bresp, 0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge sys_clk_i); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge sys_clk_i); while (rvalid !== 1'b1);
      d = rdata;
      chk("rresp", rresp, er);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd(a, 2'b00, v);
      chk("register", v, exp);
   endtask
   task automatic wait_done(output int n);
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (ready_n !== 1'b0);
   endtask
   task automatic settle();
      repeat (2) @(posedge sys_clk_i);
   endtask
   task automatic t_reset();
      logic [31:0] v;
      chk("ready_n", ready_n, 1);
      chk("ref_on", afe.ref_on, 0);
      rc(8'h00, 32'hC0);
      rc(8'h10, 32'h0);
      rd(8'h18, 2'b10, v);
      chk("unmapped", v, 0);
   endtask
   task automatic t_dac();
      wr(8'h14, 32'hA5);
      settle();
      chk("sink", sink, 0);
      wr(8'h10, 32'h1);
      settle();
      chk("power", dac_pw, 1);
      chk("sink", sink, 32'hA5);
      wr(8'h10, 32'h0);
      settle();
      chk("sink", sink, 0);
   endtask
   task automatic t_scan();
      logic [31:0] exp_scan [4] = '{32'h100, 32'h500, 32'h600, 32'h700};
      int n;
      wr(8'h0C, 32'h3);
      wr(8'h00, 32'h47);
      wait_done(n);
      // 300 setup, four of 176 acquire + 24 conversion
      chk("scan time", n > 1090 && n < 1110, 1);
      settle();
      chk("irq", irq, 1);
      chk("order", order, 12'h053);
      foreach (exp_scan[i]) rc(8'h20 + 8'(4 * i), exp_scan[i]);
      chk("ready_n", ready_n, 1);
      wr(8'h0C, 32'h0);
      settle();
      chk("irq", irq, 0);
      wr(8'h0C, 32'h3);
      settle();
      chk("irq", irq, 1);
      wr(8'h08, 32'h3);
      settle();
      chk("irq", irq, 0);
   endtask
   task automatic t_avg_diff();
      int n;
      wr(8'h00, 32'h4C);
      wait_done(n);
      chk("single time", n > 895 && n < 915, 1);
      chk("samples", cnt, 4);
      wr(8'h00, 32'hC2);
      chk("ready_n", ready_n, 1);
      rc(8'h24, 32'h502);
      wait_done(n);
      chk("diff time", n > 490 && n < 520, 1);
      rc(8'h30, 32'h800);
      rc(8'h34, 32'h940);
   endtask
   initial begin
      repeat (8) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      @(posedge sys_clk_i);
      t_reset();
      t_dac();
      t_scan();
      t_avg_diff();
      end_of_test();
   end
endmodule
bind ams_measure_seq ams_measure_seq_sva u_sva (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
   .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o), .s_axi_rready_i(s_axi_rready_i),
   .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rdata_o(s_axi_rdata_o), .s_axi_bready_i(s_axi_bready_i),
   .s_axi_bvalid_o(s_axi_bvalid_o), .afe_o(afe_o), .result_ready_n_o(result_ready_n_o),
   .dac_power_o(dac_power_o), .current_sink_out_o(current_sink_out_o));
`default_nettype wire
